// ### hdl/tcp_pkg.sv
// constants, field layouts and carrier types for the capture/compare timer
// Function
// - counter clocked by seven divided clocks or pin
// - capture edge copies counter into channel value
// - software picks capture edge polarity
// - capture event can raise an interrupt request
// - compare match sets, clears or toggles pin
// - each channel has its own compare interrupt
// - channel 1 has no pin of its own
// - unbuffered compare value takes effect immediately
// - compare flag at pulse end, wrap at period
// - pair link bit joins both channels
// - channel 1 takes over at next wrap
// - each wrap hands output to last written
// - linked pair ruled by channel 0 control
// - toggle on wrap sets the pwm period
// - modulo 255 undivided gives 256 cycles
// - value 128 of 256 gives half duty
// - buffered update starts at next period
// - all ones select picks external clock pin
// - wrap flag set when counter reaches modulo
// - no toggle on wrap gives zero duty
// - full duty with toggle gives full duty
package tcp_pkg;
    localparam int unsigned AW = 4;  // register address width
    localparam int unsigned DW = 8;  // register data width
    localparam int unsigned CW = 16; // counter width
    localparam int unsigned PSW = 3; // clock select width
    localparam int unsigned DVW = 6; // prescaler width, largest divide 64
    // register offsets
    localparam logic [AW-1:0] OFS_STAT = 4'h0;
    localparam logic [AW-1:0] OFS_CNT_HIGH = 4'h1;
    localparam logic [AW-1:0] OFS_CNT_LOW = 4'h2;
    localparam logic [AW-1:0] OFS_MODULO_HIGH = 4'h3;
    localparam logic [AW-1:0] OFS_MODULO_LOW = 4'h4;
    localparam logic [AW-1:0] OFS_CHAN0_CTRL = 4'h5;
    localparam logic [AW-1:0] OFS_CHAN0_VALUE_HIGH = 4'h6;
    localparam logic [AW-1:0] OFS_CHAN0_VALUE_LOW = 4'h7;
    localparam logic [AW-1:0] OFS_CHAN1_CTRL = 4'h8;
    localparam logic [AW-1:0] OFS_CHAN1_VALUE_HIGH = 4'h9;
    localparam logic [AW-1:0] OFS_CHAN1_VALUE_LOW = 4'ha;
    // reset values
    localparam logic [DW-1:0] STAT_RST = 8'h20;
    localparam logic [CW-1:0] MODULO_RST = 16'hffff;
    localparam logic [DW-1:0] CTRL_RST = 8'h00;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE = 16'h0001;
    // clock select codes for the external clock pin and the undivided clock
    localparam logic [PSW-1:0] PS_EXT = 3'h7;
    localparam logic [PSW-1:0] PS_UNDIV = 3'h0;
    // mode and edge/level codes
    localparam logic [1:0] MODE_CAP = 2'h0;
    localparam logic [1:0] MODE_OC = 2'h1;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h1;
    localparam logic [1:0] CAP_FALL = 2'h2;
    // main status and control layout
    typedef struct packed {
        logic wrap_flag;
        logic wrap_ie;
        logic stop;
        logic cnt_reset;
        logic rsv;
        logic [PSW-1:0] clock_select_field;
    } tcp_stat_s;
    // channel control layout, flag in the top bit
    typedef struct packed {
        logic flag;
        logic ie;
        logic pair_link_bit;
        logic mode_a;
        logic edge_b;
        logic edge_a;
        logic toggle_on_wrap_bit;
        logic full_duty_bit;
    } tcp_chctl_s;
    // one register bus request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } tcp_bus_s;
    // channel that governs the linked output
    typedef enum logic {ACT_CH0 = 1'b0, ACT_CH1 = 1'b1} tcp_act_e;
endpackage

// ### hdl/tcp_prescale.sv
// prescaler that turns the bus clock or pin edges into counter ticks
`timescale 1ns/1ps
module tcp_prescale import tcp_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [PSW-1:0] sel,
    input wire logic run,
    input wire logic clr,
    input wire logic ext_rise,
    output logic tick
);
    logic [DVW-1:0] div;      // free divider
    logic [DVW-1:0] mask;     // low bits that must be all ones
    logic int_tick;           // internal divided tick
    // code k divides by two to the k
    assign mask = ~({DVW{1'b1}} << sel);
    assign int_tick = (div & mask) == mask;
    // external pin when all select bits are set
    assign tick = run & ((sel == PS_EXT) ? ext_rise : int_tick);
    // divider stops with the counter, clears with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
        end else if (clr) begin
            div <= '0;
        end else if (run) begin
            div <= div + DVW'(1);
        end
    end
endmodule

// ### hdl/tcp_chan.sv
// one timer channel: capture and compare detection plus its flag
`timescale 1ns/1ps
module tcp_chan import tcp_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [CW-1:0] cnt,
    input wire logic [CW-1:0] val,
    input wire logic upd,
    input wire tcp_chctl_s ctl,
    input wire logic pin_rise,
    input wire logic pin_fall,
    input wire logic mute,
    input wire logic rd_ctl,
    input wire logic wr_ctl,
    input wire logic wr_zero,
    output logic cmp_hit,
    output logic cap_hit,
    output logic flag
);
    logic [1:0] mode;     // mode select pair
    logic [1:0] els;      // edge or level select
    logic is_cap;         // channel in capture mode
    logic arm;            // flag was read while set
    logic next_flag;
    logic next_arm;
    assign mode = {ctl.pair_link_bit, ctl.mode_a};
    assign els = {ctl.edge_b, ctl.edge_a};
    assign is_cap = (mode == MODE_CAP) & ~mute;
    // selected edge polarity triggers a capture
    assign cap_hit = is_cap & (((els & CAP_RISE) != '0 & pin_rise) |
                     ((els & CAP_FALL) != '0 & pin_fall));
    // match checked once per counter step
    assign cmp_hit = ~is_cap & ~mute & upd & (cnt == val);
    // event wins over a clear in the same cycle
    assign next_flag = cmp_hit | cap_hit |
                       (flag & ~(wr_ctl & wr_zero & arm));
    // a new event disarms a clear in progress
    assign next_arm = flag & ~cmp_hit & ~cap_hit & (rd_ctl | (arm & ~wr_ctl));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
            arm <= 1'b0;
        end else begin
            flag <= next_flag;
            arm <= next_arm;
        end
    end
endmodule

// ### hdl/tcp_timer.sv
// top of the capture/compare/pwm timer with its register file
`timescale 1ns/1ps
module tcp_timer import tcp_pkg::*; (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DW-1:0] RDATA,
    input wire logic EXT_TIMER_CLOCK_PIN,
    input wire logic CHAN0_PIN_I,
    output logic CHAN0_PIN_O,
    output logic CHAN0_PIN_OE,
    output logic IRQ_WRAP,
    output logic IRQ_CH0,
    output logic IRQ_CH1
);
    tcp_bus_s bus;              // packed request
    tcp_stat_s wd_stat;         // write data seen as status layout
    tcp_chctl_s wd_ctl;         // write data seen as channel layout
    tcp_stat_s stat;            // main control, flag bit unused here
    logic wrap_flag;            // counter reached modulo
    logic wrap_arm;             // wrap flag read while set
    logic [CW-1:0] cnt;         // the counter
    logic [CW-1:0] modulo;      // wrap value
    tcp_chctl_s c0;             // channel 0 control, flag bit unused
    tcp_chctl_s c1;             // channel 1 control, flag bit unused
    logic [CW-1:0] v0;          // channel 0 value
    logic [CW-1:0] v1;          // channel 1 value
    logic step;                 // counter steps at this edge
    logic tick;                 // counter step request
    logic ext1, ext2, ext3;     // clock pin synchroniser and edge stage
    logic pin1, pin2, pin3;     // channel pin synchroniser and edge stage
    logic ext_rise;
    logic pin_rise;
    logic pin_fall;
    logic pin;                  // channel 0 output level
    tcp_act_e act;              // channel governing linked output
    tcp_act_e last_w;           // channel written most recently while linked, channel 0 when unlinked
    logic c0_cmp, c0_cap, c0_flag;
    logic c1_cmp, c1_cap, c1_flag;
    logic [DW-1:0] rd_mux;
    // register decode
    logic wr_stat, rd_stat, cnt_clr;
    logic wr_c0, rd_c0, wr_c1, rd_c1;
    logic wr_v0h, wr_v0l, wr_v1h, wr_v1l;
    logic wr_zero;
    logic link;                 // pair linked, buffered mode
    logic oc_on;                // channel 0 drives its pin
    logic wrap_hit;             // counter at modulo this step
    logic [1:0] els0;
    logic [1:0] mode0;
    logic pulse_lvl;            // active level of the pwm pulse
    logic [CW-1:0] act_val;
    logic next_pin;
    logic next_wrap_flag;
    logic next_wrap_arm;
    logic [CW-1:0] next_cnt;
    tcp_act_e next_act;
    tcp_act_e next_last_w;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign wr_stat = bus.wr & (bus.addr == OFS_STAT);
    assign rd_stat = bus.rd & (bus.addr == OFS_STAT);
    assign wr_c0 = bus.wr & (bus.addr == OFS_CHAN0_CTRL);
    assign rd_c0 = bus.rd & (bus.addr == OFS_CHAN0_CTRL);
    assign wr_c1 = bus.wr & (bus.addr == OFS_CHAN1_CTRL);
    assign rd_c1 = bus.rd & (bus.addr == OFS_CHAN1_CTRL);
    assign wr_v0h = bus.wr & (bus.addr == OFS_CHAN0_VALUE_HIGH);
    assign wr_v0l = bus.wr & (bus.addr == OFS_CHAN0_VALUE_LOW);
    assign wr_v1h = bus.wr & (bus.addr == OFS_CHAN1_VALUE_HIGH);
    assign wr_v1l = bus.wr & (bus.addr == OFS_CHAN1_VALUE_LOW);
    assign wd_stat = bus.wdata;
    assign wd_ctl = bus.wdata;
    // flags clear only by writing zero into their bit
    assign wr_zero = ~wd_ctl.flag;
    // counter reset is a write-only pulse, never stored
    assign cnt_clr = wr_stat & wd_stat.cnt_reset;

    // pin synchronisers, first stage feeds only the second
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ext1 <= 1'b0;
            ext2 <= 1'b0;
            ext3 <= 1'b0;
            pin1 <= 1'b0;
            pin2 <= 1'b0;
            pin3 <= 1'b0;
        end else begin
            ext1 <= EXT_TIMER_CLOCK_PIN;
            ext2 <= ext1;
            ext3 <= ext2;
            pin1 <= CHAN0_PIN_I;
            pin2 <= pin1;
            pin3 <= pin2;
        end
    end
    assign ext_rise = ext2 & ~ext3;
    assign pin_rise = pin2 & ~pin3;
    assign pin_fall = ~pin2 & pin3;

    // clock source choice and division
    tcp_prescale u_pre (
        .clk(MCLK),
        .rst_n(RST_N),
        .sel(stat.clock_select_field),
        .run(~stat.stop),
        .clr(cnt_clr),
        .ext_rise(ext_rise),
        .tick(tick)
    );

    // counter steps per tick, back to zero after the modulo value
    assign next_cnt = (cnt == modulo) ? CNT_ZERO : cnt + CNT_ONE;
    // a counter reset write beats a tick in the same cycle
    assign step = tick & ~cnt_clr;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= CNT_ZERO;
        end else if (cnt_clr) begin
            cnt <= CNT_ZERO;
        end else if (step) begin
            cnt <= next_cnt;
        end
    end
    // wrap and compare both act at the edge that enters the next value,
    // so a pulse of value n lasts exactly n ticks at any prescale
    assign wrap_hit = step & (cnt == modulo);

    // wrap flag: set wins over the read-then-write-zero clear
    assign next_wrap_flag = wrap_hit |
                            (wrap_flag & ~(wr_stat & wr_zero & wrap_arm));
    assign next_wrap_arm = wrap_flag & ~wrap_hit &
                           (rd_stat | (wrap_arm & ~wr_stat));
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wrap_flag <= 1'b0;
            wrap_arm <= 1'b0;
        end else begin
            wrap_flag <= next_wrap_flag;
            wrap_arm <= next_wrap_arm;
        end
    end

    // control registers; reset bit and reserved bit are never kept
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            stat <= STAT_RST;
            c0 <= CTRL_RST;
            c1 <= CTRL_RST;
        end else begin
            if (wr_stat) begin
                stat <= bus.wdata;
                stat.wrap_flag <= 1'b0;
                stat.cnt_reset <= 1'b0;
                stat.rsv <= 1'b0;
            end
            if (wr_c0) begin
                c0 <= bus.wdata;
                c0.flag <= 1'b0;
            end
            if (wr_c1) begin
                c1 <= bus.wdata;
                c1.flag <= 1'b0;
                c1.pair_link_bit <= 1'b0; // channel 1 has no link bit
            end
        end
    end

    // modulo registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            modulo <= MODULO_RST;
        end else if (bus.wr & (bus.addr == OFS_MODULO_HIGH)) begin
            modulo[CW-1:DW] <= bus.wdata;
        end else if (bus.wr & (bus.addr == OFS_MODULO_LOW)) begin
            modulo[DW-1:0] <= bus.wdata;
        end
    end

    // value registers: a capture wins over a software write
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            v0 <= CNT_ZERO;
            v1 <= CNT_ZERO;
        end else begin
            if (c0_cap) begin
                v0 <= cnt;
            end else if (wr_v0h) begin
                v0[CW-1:DW] <= bus.wdata;
            end else if (wr_v0l) begin
                v0[DW-1:0] <= bus.wdata;
            end
            if (c1_cap) begin
                v1 <= cnt;
            end else if (wr_v1h) begin
                v1[CW-1:DW] <= bus.wdata;
            end else if (wr_v1l) begin
                v1[DW-1:0] <= bus.wdata;
            end
        end
    end

    // linked pair: channel 0 control rules the joint output
    assign link = c0.pair_link_bit;
    // last written channel takes over only at a wrap
    assign next_last_w = ~link ? ACT_CH0 :
                         (wr_v1h | wr_v1l) ? ACT_CH1 :
                         (wr_v0h | wr_v0l) ? ACT_CH0 : last_w;
    assign next_act = ~link ? ACT_CH0 :
                      wrap_hit ? last_w : act;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            act <= ACT_CH0;
            last_w <= ACT_CH0;
        end else begin
            act <= next_act;
            last_w <= next_last_w;
        end
    end
    assign act_val = (act == ACT_CH1) ? v1 : v0;

    // channel 0 compares against the governing value
    tcp_chan u_ch0 (
        .clk(MCLK),
        .rst_n(RST_N),
        .cnt(next_cnt),
        .val(act_val),
        .upd(step),
        .ctl(c0),
        .pin_rise(pin_rise),
        .pin_fall(pin_fall),
        .mute(1'b0),
        .rd_ctl(rd_c0),
        .wr_ctl(wr_c0),
        .wr_zero(wr_zero),
        .cmp_hit(c0_cmp),
        .cap_hit(c0_cap),
        .flag(c0_flag)
    );
    // channel 1 has no pin and is silent while linked
    tcp_chan u_ch1 (
        .clk(MCLK),
        .rst_n(RST_N),
        .cnt(next_cnt),
        .val(v1),
        .upd(step),
        .ctl(c1),
        .pin_rise(1'b0),
        .pin_fall(1'b0),
        .mute(link),
        .rd_ctl(rd_c1),
        .wr_ctl(wr_c1),
        .wr_zero(wr_zero),
        .cmp_hit(c1_cmp),
        .cap_hit(c1_cap),
        .flag(c1_flag)
    );

    // channel 0 output stage
    assign els0 = {c0.edge_b, c0.edge_a};
    assign mode0 = {c0.pair_link_bit, c0.mode_a};
    assign oc_on = (link | (mode0 == MODE_OC)) & (els0 != ELS_OFF);
    // clear on compare means the pulse is high
    assign pulse_lvl = (els0 == ELS_CLEAR);
    // wrap first, compare after, so a compare at value zero still acts
    always_comb begin
        next_pin = pin;
        if (wrap_hit & c0.toggle_on_wrap_bit) begin
            // full duty pins the active level at every wrap
            next_pin = c0.full_duty_bit ? pulse_lvl : ~pin;
        end
        if (c0_cmp & ~c0.full_duty_bit) begin
            unique case (els0)
                ELS_TOGGLE: next_pin = ~next_pin;
                ELS_CLEAR: next_pin = 1'b0;
                ELS_SET: next_pin = 1'b1;
                ELS_OFF: next_pin = next_pin;
            endcase
        end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pin <= 1'b0;
        end else if (oc_on) begin
            pin <= next_pin;
        end
    end
    assign CHAN0_PIN_O = pin;
    assign CHAN0_PIN_OE = oc_on;

    // interrupt requests: flag and enable, channel 1 also masked while linked; flags set at the event
    assign IRQ_WRAP = wrap_flag & stat.wrap_ie;
    assign IRQ_CH0 = c0_flag & c0.ie;
    assign IRQ_CH1 = c1_flag & c1.ie & ~link;

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        unique case (bus.addr)
            OFS_STAT: rd_mux = {wrap_flag, stat.wrap_ie, stat.stop,
                                2'h0, stat.clock_select_field};
            OFS_CNT_HIGH: rd_mux = cnt[CW-1:DW];
            OFS_CNT_LOW: rd_mux = cnt[DW-1:0];
            OFS_MODULO_HIGH: rd_mux = modulo[CW-1:DW];
            OFS_MODULO_LOW: rd_mux = modulo[DW-1:0];
            OFS_CHAN0_CTRL: rd_mux = {c0_flag, c0[DW-2:0]};
            OFS_CHAN0_VALUE_HIGH: rd_mux = v0[CW-1:DW];
            OFS_CHAN0_VALUE_LOW: rd_mux = v0[DW-1:0];
            OFS_CHAN1_CTRL: rd_mux = {c1_flag, c1[DW-2:0]};
            OFS_CHAN1_VALUE_HIGH: rd_mux = v1[CW-1:DW];
            OFS_CHAN1_VALUE_LOW: rd_mux = v1[DW-1:0];
            default: rd_mux = '0;
        endcase
    end
    // read data valid only in the cycle after the strobe
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= bus.rd ? rd_mux : '0;
        end
    end

    // checks on the timer behaviour
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_ch1_armed;
        link && last_w == ACT_CH1;
    endsequence
    sequence s_wrap;
        wrap_hit && !cnt_clr;
    endsequence

    a_wrap_to_zero: assert property (
        tick && cnt == modulo && !cnt_clr |=> cnt == CNT_ZERO)
        else $error("counter did not wrap to zero");
    a_wrap_flag_set: assert property (
        wrap_hit |=> wrap_flag)
        else $error("wrap flag missing after modulo");
    a_ext_clock_sel: assert property (
        stat.clock_select_field == PS_EXT && tick |-> ext_rise)
        else $error("counter stepped without pin edge");
    a_undiv_rate: assert property (
        stat.clock_select_field == PS_UNDIV && !stat.stop |-> tick)
        else $error("undivided clock missed a step");
    a_capture_copy: assert property (
        c0_cap |=> v0 == $past(cnt))
        else $error("capture did not copy counter");
    a_capture_edge: assert property (
        !link && mode0 == MODE_CAP && els0 == CAP_RISE && pin_fall
        |-> !c0_cap)
        else $error("capture on wrong edge");
    a_capture_irq: assert property (
        c0_cap && c0.ie && !wr_c0 |=> IRQ_CH0)
        else $error("capture raised no request");
    a_ch1_irq: assert property (
        c1_cmp && c1.ie && !wr_c1 && !link ##1 !link |-> IRQ_CH1)
        else $error("channel 1 compare raised no request");
    a_ch1_silent: assert property (
        link |-> !c1_cmp && !c1_cap)
        else $error("channel 1 active while linked");
    a_compare_clear: assert property (
        oc_on && c0_cmp && els0 == ELS_CLEAR && !c0.full_duty_bit
        |=> !CHAN0_PIN_O)
        else $error("compare did not clear pin");
    a_hand_over: assert property (
        s_ch1_armed ##0 s_wrap |=> act == ACT_CH1 || !link)
        else $error("channel 1 did not take over at wrap");
    a_act_hold: assert property (
        link && !wrap_hit ##1 link |-> act == $past(act))
        else $error("active channel changed mid period");
    a_full_duty: assert property (
        oc_on && wrap_hit && c0.toggle_on_wrap_bit && c0.full_duty_bit
        && els0 == ELS_CLEAR |=> CHAN0_PIN_O ##1 CHAN0_PIN_O || !oc_on)
        else $error("full duty not held high");
    a_zero_duty: assert property (
        oc_on && !c0.toggle_on_wrap_bit && els0 == ELS_CLEAR
        && !CHAN0_PIN_O |=> !CHAN0_PIN_O)
        else $error("zero duty output rose");
    a_value_write: assert property (
        wr_v0l && !c0_cap |=> v0[DW-1:0] == $past(bus.wdata))
        else $error("compare value not taken at once");
endmodule

// ### verification/tcp_ext_src.sv
// far side model: external counter clock source and capture pin driver
`timescale 1ns/1ps
module tcp_ext_src (
    input wire logic clk,
    output logic ext_clk,
    output logic pin
);
    // both lines rest low, the clock stands still between bursts
    initial begin
        ext_clk = 1'b0;
        pin = 1'b0;
    end
    // pulses slower than half the bus rate so every edge is seen
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clk <= 1'b1;
            repeat (2) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    // one level change on the capture pin
    task automatic set_pin(input logic v);
        @(posedge clk);
        pin <= v;
    endtask
endmodule

// ### verification/test_tcp_timer.sv
// self-checking bench for the capture/compare/pwm timer
`timescale 1ns/1ps
module test_tcp_timer import tcp_pkg::*;;
    logic mclk, rst_n, wr, rd, pin_o, oe, irq_w, irq0, irq1, ext_clk, pin_i;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata, v;
    int err_total = 0;
    int n_tests = 0;
    int h, h1, r;
    tcp_ext_src src (.clk(mclk), .ext_clk(ext_clk), .pin(pin_i));
    tcp_timer dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .EXT_TIMER_CLOCK_PIN(ext_clk),
        .CHAN0_PIN_I(pin_i), .CHAN0_PIN_O(pin_o), .CHAN0_PIN_OE(oe),
        .IRQ_WRAP(irq_w), .IRQ_CH0(irq0), .IRQ_CH1(irq1));
    // 50 ns bus clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // one compare, counted; mismatches reported at once
    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // single-cycle write strobe, one idle edge after it
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // high cycles and rising edges of the pin over 2048 cycles
    task automatic meas(output int hi, output int rises);
        logic p;
        hi = 0;
        rises = 0;
        p = pin_o;
        repeat (2048) begin
            @(posedge mclk);
            #1;
            if (pin_o === 1'b1) hi++;
            if (pin_o === 1'b1 && p === 1'b0) rises++;
            p = pin_o;
        end
    endtask
    // verdict, reached from the tests and from the watchdog
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog: about twice the expected run length
    initial begin
        #(50 * 40000);
        err_total++;
        conclude();
    end
    // test sequence
    initial begin
        {wr, rd, addr, wdata} = '0;
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(OFS_STAT, v);
        chk("status reset", v, STAT_RST);
        rd_reg(OFS_MODULO_HIGH, v);
        chk("modulo reset", v, MODULO_RST[15:8]);
        $display("test reset done");
        // counter cleared and stopped, then fed from the pin
        wr_reg(OFS_STAT, 8'h37);
        wr_reg(OFS_STAT, 8'h07);
        src.pulses(5);
        repeat (8) @(posedge mclk);
        wr_reg(OFS_STAT, 8'h27);
        rd_reg(OFS_CNT_LOW, v);
        chk("pin clock count", v, 8'h05);
        $display("test external clock done");
        // falling edge selected: a rise must not capture
        wr_reg(OFS_CHAN0_CTRL, 8'h48);
        src.set_pin(1'b1);
        repeat (6) @(posedge mclk);
        rd_reg(OFS_CHAN0_CTRL, v);
        chk("no capture on rise", v, 8'h48);
        src.set_pin(1'b0);
        repeat (6) @(posedge mclk);
        rd_reg(OFS_CHAN0_CTRL, v);
        chk("capture flag", v, 8'hc8);
        chk("capture irq", irq0, 1'b1);
        rd_reg(OFS_CHAN0_VALUE_LOW, v);
        chk("captured count", v, 8'h05);
        $display("test capture done");
        // channel 1 kept out of capture: plain compare, request enabled
        wr_reg(OFS_CHAN1_CTRL, 8'h50);
        // pwm, modulo 255, undivided clock, width 64 then 128
        wr_reg(OFS_MODULO_HIGH, 8'h00);
        wr_reg(OFS_MODULO_LOW, 8'hff);
        wr_reg(OFS_CHAN0_CTRL, 8'h5a);
        wr_reg(OFS_CHAN0_VALUE_LOW, 8'h40);
        wr_reg(OFS_STAT, 8'h30);
        wr_reg(OFS_STAT, 8'h40);
        meas(h1, r);
        meas(h1, r);
        chk("pwm periods", r[15:0], 16'h0008);
        chk("width 64", h1[15:0], 16'd512);
        chk("pin driven", oe, 1'b1);
        chk("wrap irq", irq_w, 1'b1);
        chk("chan1 irq", irq1, 1'b1);
        rd_reg(OFS_CHAN0_CTRL, v);
        chk("compare flag", v, 8'hda);
        // larger width goes in right after a wrap, as a wrap handler would
        rd_reg(OFS_STAT, v);
        chk("wrap flag", v, 8'hc0);
        wr_reg(OFS_STAT, 8'h40);
        while (irq_w !== 1'b1) @(posedge mclk);
        wr_reg(OFS_CHAN0_VALUE_LOW, 8'h80);
        meas(h, r);
        meas(h, r);
        chk("width step", h[15:0] - h1[15:0], 16'd512);
        chk("half duty", h[15:0], 16'd1024);
        $display("test pwm done");
        // linked pair: a channel 1 write governs from the next period
        wr_reg(OFS_CHAN0_CTRL, 8'h3a);
        wr_reg(OFS_CHAN1_VALUE_LOW, 8'h40);
        meas(h, r);
        meas(h, r);
        chk("linked width", h[15:0], 16'd512);
        chk("chan1 irq silent", irq1, 1'b0);
        $display("test buffered done");
        // no toggle on wrap, then full duty
        wr_reg(OFS_CHAN0_CTRL, 8'h18);
        meas(h, r);
        meas(h, r);
        chk("zero duty", h[15:0], 16'h0000);
        wr_reg(OFS_CHAN0_CTRL, 8'h1b);
        meas(h, r);
        meas(h, r);
        chk("full duty", h[15:0], 16'd2048);
        $display("test duty limits done");
        conclude();
    end
endmodule
